// [logic/gpc_port_config.sv]
`timescale 1ns/100ps
`default_nettype none

`include "gpc_regs.svh"

module gpc_port_config (
    // Clock and reset.
    input  wire logic                      clk,
    input  wire logic                      resetn,
    // Core data-space access.
    input  wire logic [7:0]                bus_addr,
    input  wire logic [7:0]                bus_wdata,
    input  wire logic                      bus_write,
    input  wire logic                      bus_read,
    output logic      [7:0]                bus_rdata,
    // Port A pads.
    input  wire logic [7:0]                pin_in_a,
    output logic      [7:0]                pin_out_a,
    output logic      [7:0]                pin_oe_a,
    output logic      [7:0]                pullup_en_a,
    output logic      [7:0]                analog_sel_a,
    // Port B pads.
    input  wire logic [7:0]                pin_in_b,
    output logic      [7:0]                pin_out_b,
    output logic      [7:0]                pin_oe_b,
    output logic      [7:0]                pullup_en_b,
    output logic      [7:0]                analog_sel_b,
    // Port C pads.
    input  wire logic [7:0]                pin_in_c,
    output logic      [7:0]                pin_out_c,
    output logic      [7:0]                pin_oe_c,
    output logic      [7:0]                pullup_en_c,
    output logic      [7:0]                analog_sel_c,
    // Interrupt controller.
    input  wire gpc_pkg::gpc_trigger_type  trigger_mode_a,
    input  wire gpc_pkg::gpc_trigger_type  trigger_mode_b,
    input  wire gpc_pkg::gpc_trigger_type  trigger_mode_c,
    output logic                           port_irq_request,
    // Auto-reload timer.
    input  wire logic                      timer_pwm_out_enable,
    input  wire logic                      auto_timer_pwm_pin,
    output logic                           auto_timer_input_pin,
    // Serial peripheral.
    input  wire logic                      spi_data_out,
    output logic                           spi_data_in,
    output logic                           spi_clock_in,
    // UART.
    input  wire logic                      uart_transmit_active,
    input  wire logic                      uart_transmit_pin,
    output logic                           uart_receive_pin
);

    logic [1:0] reset_sync;
    logic       sys_resetn;

    gpc_pkg::gpc_top_state_type state;
    gpc_pkg::gpc_top_state_type next_state;

    // Bits as they drive the pads, after the alternate functions.
    logic [7:0] drive_dir_a;
    logic [7:0] drive_option_a;
    logic [7:0] drive_value_a;
    logic [7:0] drive_dir_b;
    logic [7:0] drive_option_b;
    logic [7:0] drive_value_b;

    logic [7:0] level_a;
    logic [7:0] level_b;
    logic [7:0] level_c;
    logic [7:0] read_a;
    logic [7:0] read_b;
    logic [7:0] read_c;
    logic       irq_a;
    logic       irq_b;
    logic       irq_c;

    // Reset is taken asynchronously and released on the clock.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reset_sync <= 2'h0;
        end else begin
            reset_sync <= {reset_sync[0], 1'b1};
        end
    end

    assign sys_resetn = reset_sync[1];

    // Alternate functions of port A.
    always_comb begin
        drive_dir_a    = state.dir_a;
        drive_option_a = state.option_a;
        drive_value_a  = state.value_a;
        // Serial data is wired-and with the value bit in open-drain only.
        if (state.dir_a[`GPC_SPI_OUT_LINE]
            && !state.option_a[`GPC_SPI_OUT_LINE]) begin
            drive_value_a[`GPC_SPI_OUT_LINE] =
                state.value_a[`GPC_SPI_OUT_LINE] & spi_data_out;
        end
    end

    // Alternate functions of port B.
    always_comb begin
        drive_dir_b    = state.dir_b;
        drive_option_b = state.option_b;
        drive_value_b  = state.value_b;
        if (timer_pwm_out_enable) begin
            drive_dir_b[`GPC_PWM_LINE]    = 1'b1;
            drive_option_b[`GPC_PWM_LINE] = 1'b1;
            drive_value_b[`GPC_PWM_LINE]  = auto_timer_pwm_pin;
        end
        if (state.dir_b[`GPC_UART_TX_LINE] && uart_transmit_active) begin
            drive_value_b[`GPC_UART_TX_LINE] = uart_transmit_pin;
        end
    end

    // Peripheral inputs come from the filtered pin levels at all times.
    always_comb begin
        spi_data_in          = level_a[`GPC_SPI_IN_LINE];
        spi_clock_in         = level_a[`GPC_SPI_CLK_LINE];
        auto_timer_input_pin = level_b[`GPC_TIMER_IN_LINE];
        uart_receive_pin     = level_b[`GPC_UART_RX_LINE];
        bus_rdata            = state.rdata;
        port_irq_request     = state.irq;
    end

    // Register writes and read capture.
    always_comb begin
        next_state = state;
        if (bus_write) begin
            case (bus_addr)
                `GPC_ADDR_VALUE_A: begin
                    next_state.value_a = bus_wdata;
                end
                `GPC_ADDR_VALUE_B: begin
                    next_state.value_b = bus_wdata;
                end
                `GPC_ADDR_VALUE_C: begin
                    next_state.value_c = bus_wdata;
                end
                `GPC_ADDR_DIR_A: begin
                    next_state.dir_a = bus_wdata;
                end
                `GPC_ADDR_DIR_B: begin
                    next_state.dir_b = bus_wdata;
                end
                `GPC_ADDR_DIR_C: begin
                    next_state.dir_c = bus_wdata;
                end
                `GPC_ADDR_OPTION_A: begin
                    next_state.option_a = bus_wdata;
                end
                `GPC_ADDR_OPTION_B: begin
                    next_state.option_b = bus_wdata;
                end
                `GPC_ADDR_OPTION_C: begin
                    next_state.option_c = bus_wdata;
                end
                default: begin
                    next_state.value_a = state.value_a;
                end
            endcase
        end
        if (bus_read) begin
            case (bus_addr)
                `GPC_ADDR_VALUE_A: begin
                    next_state.rdata = read_a;
                end
                `GPC_ADDR_VALUE_B: begin
                    next_state.rdata = read_b;
                end
                `GPC_ADDR_VALUE_C: begin
                    next_state.rdata = read_c;
                end
                `GPC_ADDR_DIR_A: begin
                    next_state.rdata = state.dir_a;
                end
                `GPC_ADDR_DIR_B: begin
                    next_state.rdata = state.dir_b;
                end
                `GPC_ADDR_DIR_C: begin
                    next_state.rdata = state.dir_c;
                end
                `GPC_ADDR_OPTION_A: begin
                    next_state.rdata = state.option_a;
                end
                `GPC_ADDR_OPTION_B: begin
                    next_state.rdata = state.option_b;
                end
                `GPC_ADDR_OPTION_C: begin
                    next_state.rdata = state.option_c;
                end
                default: begin
                    next_state.rdata = `GPC_UNMAPPED_READ;
                end
            endcase
        end
        next_state.irq = irq_a | irq_b | irq_c;
    end

    always_ff @(posedge clk or negedge sys_resetn) begin
        if (!sys_resetn) begin
            state.value_a  <= `GPC_REG_RESET;
            state.value_b  <= `GPC_REG_RESET;
            state.value_c  <= `GPC_REG_RESET;
            state.dir_a    <= `GPC_REG_RESET;
            state.dir_b    <= `GPC_REG_RESET;
            state.dir_c    <= `GPC_REG_RESET;
            state.option_a <= `GPC_REG_RESET;
            state.option_b <= `GPC_REG_RESET;
            state.option_c <= `GPC_REG_RESET;
            state.rdata    <= `GPC_REG_RESET;
            state.irq      <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    gpc_port_lines #(
        .ANALOG_LINES (`GPC_ANALOG_LINES_A)
    ) port_a_lines (
        .clk          (clk),
        .sys_resetn   (sys_resetn),
        .dir          (state.dir_a),
        .option       (state.option_a),
        .value        (state.value_a),
        .drive_dir    (drive_dir_a),
        .drive_option (drive_option_a),
        .drive_value  (drive_value_a),
        .trigger_mode (trigger_mode_a),
        .pin_in       (pin_in_a),
        .pin_out      (pin_out_a),
        .pin_oe       (pin_oe_a),
        .pullup_en    (pullup_en_a),
        .analog_sel   (analog_sel_a),
        .pin_level    (level_a),
        .read_value   (read_a),
        .irq_req      (irq_a)
    );

    gpc_port_lines #(
        .ANALOG_LINES (`GPC_ANALOG_LINES_B)
    ) port_b_lines (
        .clk          (clk),
        .sys_resetn   (sys_resetn),
        .dir          (state.dir_b),
        .option       (state.option_b),
        .value        (state.value_b),
        .drive_dir    (drive_dir_b),
        .drive_option (drive_option_b),
        .drive_value  (drive_value_b),
        .trigger_mode (trigger_mode_b),
        .pin_in       (pin_in_b),
        .pin_out      (pin_out_b),
        .pin_oe       (pin_oe_b),
        .pullup_en    (pullup_en_b),
        .analog_sel   (analog_sel_b),
        .pin_level    (level_b),
        .read_value   (read_b),
        .irq_req      (irq_b)
    );

    // Port C has no alternate function, so it drives from its registers.
    gpc_port_lines #(
        .ANALOG_LINES (`GPC_ANALOG_LINES_C)
    ) port_c_lines (
        .clk          (clk),
        .sys_resetn   (sys_resetn),
        .dir          (state.dir_c),
        .option       (state.option_c),
        .value        (state.value_c),
        .drive_dir    (state.dir_c),
        .drive_option (state.option_c),
        .drive_value  (state.value_c),
        .trigger_mode (trigger_mode_c),
        .pin_in       (pin_in_c),
        .pin_out      (pin_out_c),
        .pin_oe       (pin_oe_c),
        .pullup_en    (pullup_en_c),
        .analog_sel   (analog_sel_c),
        .pin_level    (level_c),
        .read_value   (read_c),
        .irq_req      (irq_c)
    );

endmodule : gpc_port_config

`default_nettype wire

// [logic/gpc_regs.svh]
`ifndef GPC_REGS_SVH
`define GPC_REGS_SVH

// Data-space byte addresses of the port registers.
`define GPC_ADDR_VALUE_A      8'hC0
`define GPC_ADDR_VALUE_B      8'hC1
`define GPC_ADDR_VALUE_C      8'hC3
`define GPC_ADDR_DIR_A        8'hC4
`define GPC_ADDR_DIR_B        8'hC5
`define GPC_ADDR_DIR_C        8'hC6
`define GPC_ADDR_OPTION_A     8'hCC
`define GPC_ADDR_OPTION_B     8'hCE
`define GPC_ADDR_OPTION_C     8'hCF

// Reset value of every port register and answer to an unmapped read.
`define GPC_REG_RESET         8'h00
`define GPC_UNMAPPED_READ     8'h00

// Line positions of the alternate functions.
`define GPC_PWM_LINE          3'h7
`define GPC_TIMER_IN_LINE     3'h6
`define GPC_SPI_OUT_LINE      3'h7
`define GPC_SPI_IN_LINE       3'h6
`define GPC_SPI_CLK_LINE      3'h5
`define GPC_UART_RX_LINE      3'h1
`define GPC_UART_TX_LINE      3'h0

// Lines that have a path to the converter multiplexer.
`define GPC_ANALOG_LINES_A    8'h00
`define GPC_ANALOG_LINES_B    8'hFF
`define GPC_ANALOG_LINES_C    8'hF0

`endif

// [logic/gpc_pkg.sv]
package gpc_pkg;

    // Trigger condition of the combined port interrupt, one per port.
    typedef enum logic [1:0] {
        GPC_TRIG_FALLING,
        GPC_TRIG_RISING,
        GPC_TRIG_LOW_LEVEL
    } gpc_trigger_type;

    // State of one port's line logic.
    typedef struct packed {
        logic [7:0] sync_1;
        logic [7:0] sync_2;
        logic [7:0] sync_3;
        logic [7:0] level;
        logic [7:0] level_prev;
        logic       irq;
    } gpc_lines_state_type;

    // State of the register block.
    typedef struct packed {
        logic [7:0] value_a;
        logic [7:0] value_b;
        logic [7:0] value_c;
        logic [7:0] dir_a;
        logic [7:0] dir_b;
        logic [7:0] dir_c;
        logic [7:0] option_a;
        logic [7:0] option_b;
        logic [7:0] option_c;
        logic [7:0] rdata;
        logic       irq;
    } gpc_top_state_type;

endpackage : gpc_pkg

// [logic/gpc_port_lines.sv]
`timescale 1ns/100ps
`default_nettype none

module gpc_port_lines #(
    parameter logic [7:0] ANALOG_LINES = 8'h00
) (
    // Clock and synchronised reset.
    input  wire logic                      clk,
    input  wire logic                      sys_resetn,
    // Stored register bits.
    input  wire logic [7:0]                dir,
    input  wire logic [7:0]                option,
    input  wire logic [7:0]                value,
    // Drive bits after alternate functions.
    input  wire logic [7:0]                drive_dir,
    input  wire logic [7:0]                drive_option,
    input  wire logic [7:0]                drive_value,
    // Interrupt trigger selection.
    input  wire gpc_pkg::gpc_trigger_type  trigger_mode,
    // Pads.
    input  wire logic [7:0]                pin_in,
    output logic      [7:0]                pin_out,
    output logic      [7:0]                pin_oe,
    output logic      [7:0]                pullup_en,
    output logic      [7:0]                analog_sel,
    // Results.
    output logic      [7:0]                pin_level,
    output logic      [7:0]                read_value,
    output logic                           irq_req
);

    gpc_pkg::gpc_lines_state_type state;
    gpc_pkg::gpc_lines_state_type next_state;

    logic [7:0] irq_lines;
    logic [7:0] push_pull;
    logic [7:0] open_drain;

    always_comb begin
        push_pull  = drive_dir & drive_option;
        open_drain = drive_dir & ~drive_option;
        pin_out    = push_pull & drive_value;
        pin_oe     = push_pull | (open_drain & ~drive_value);
        pullup_en  = ~drive_dir & ~drive_value;
        analog_sel = ~drive_dir & drive_option & drive_value
                   & ANALOG_LINES;
        pin_level  = state.level;
        read_value = (dir & value) | (~dir & state.level);
        irq_lines  = ~dir & option & ~value;
        irq_req    = state.irq;
    end

    always_comb begin
        next_state        = state;
        next_state.sync_1 = pin_in;
        next_state.sync_2 = state.sync_1;
        next_state.sync_3 = state.sync_2;
        next_state.level  = (~(state.sync_2 ^ state.sync_3) & state.sync_3)
                          | ((state.sync_2 ^ state.sync_3) & state.level);
        next_state.level_prev = state.level;
        case (trigger_mode)
            gpc_pkg::GPC_TRIG_FALLING: begin
                next_state.irq = |(irq_lines & state.level_prev
                                   & ~state.level);
            end
            gpc_pkg::GPC_TRIG_RISING: begin
                next_state.irq = |(irq_lines & ~state.level_prev
                                   & state.level);
            end
            gpc_pkg::GPC_TRIG_LOW_LEVEL: begin
                next_state.irq = |(irq_lines & ~state.level);
            end
            default: begin
                next_state.irq = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge sys_resetn) begin
        if (!sys_resetn) begin
            // Lines leave reset as pulled-up inputs, so the filter starts
            // high and no false rising edge follows the release.
            state <= '{sync_1: 8'hFF, sync_2: 8'hFF, sync_3: 8'hFF,
                       level: 8'hFF, level_prev: 8'hFF, irq: 1'b0};
        end else begin
            state <= next_state;
        end
    end

endmodule : gpc_port_lines

`default_nettype wire

// [verification/gpc_port_config_properties.sv]
`timescale 1ns/100ps
`default_nettype none
`include "gpc_regs.svh"
module gpc_port_config_properties (
    // Clock, reset and register bus.
    input wire logic                    clk,
    input wire logic                    resetn,
    input wire logic [7:0]              bus_addr,
    input wire logic [7:0]              bus_wdata,
    input wire logic                    bus_write,
    input wire logic                    bus_read,
    input wire logic [7:0]              bus_rdata,
    // Pads.
    input wire logic [7:0]              pin_in_a,
    input wire logic [7:0]              pin_oe_b,
    input wire logic [7:0]              pin_out_b,
    input wire logic [7:0]              pin_oe_c,
    input wire logic [7:0]              pullup_en_c,
    input wire logic [7:0]              analog_sel_a,
    input wire logic [7:0]              analog_sel_c,
    // Peripherals.
    input wire gpc_pkg::gpc_trigger_type trigger_mode_c,
    input wire logic                    port_irq_request,
    input wire logic                    timer_pwm_out_enable,
    input wire logic                    auto_timer_pwm_pin,
    input wire logic                    spi_data_in,
    input wire logic                    uart_transmit_active,
    input wire logic                    uart_transmit_pin
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence stored_write_then_read;
        bus_write && bus_addr inside {`GPC_ADDR_DIR_A, `GPC_ADDR_DIR_B,
            `GPC_ADDR_DIR_C, `GPC_ADDR_OPTION_A, `GPC_ADDR_OPTION_B,
            `GPC_ADDR_OPTION_C} ##1 bus_read && $stable(bus_addr);
    endsequence
    sequence pad_a6_quiet;
        $stable(pin_in_a[6])[*8] ##0 $past(resetn, 12);
    endsequence

    AST_RESET_STATE: assert property ($rose(resetn) |-> pin_oe_c == 8'h00
        && pullup_en_c == 8'hFF && analog_sel_c == 8'h00)
        else $error("port state after reset wrong");
    AST_WRITE_READ: assert property (stored_write_then_read |=>
        bus_rdata == $past(bus_wdata, 2))
        else $error("register read back differs from write");
    AST_RDATA_HOLD: assert property (!bus_read |=> $stable(bus_rdata))
        else $error("read data changed without a read");
    AST_PULLUP_INPUT_ONLY: assert property ((pin_oe_c & pullup_en_c) == 8'h00)
        else $error("pull-up on a driving line");
    AST_ANALOG_CAPABLE: assert property (analog_sel_a == 8'h00
        && analog_sel_c[3:0] == 4'h0)
        else $error("analog path on a line without one");
    AST_PWM_OVERRIDE: assert property (timer_pwm_out_enable |-> pin_oe_b[7]
        && pin_out_b[7] == auto_timer_pwm_pin)
        else $error("pwm line not overridden");
    AST_UART_TX: assert property (uart_transmit_active && pin_oe_b[0] |->
        pin_out_b[0] == uart_transmit_pin)
        else $error("uart transmit not on line 0");
    AST_SPI_IN: assert property (pad_a6_quiet |-> spi_data_in == pin_in_a[6])
        else $error("serial data input does not follow pad");
    // The request lags the trigger select by two registers.
    AST_IRQ_PULSE: assert property ($past(trigger_mode_c) !=
        gpc_pkg::GPC_TRIG_LOW_LEVEL && $past(trigger_mode_c, 2) !=
        gpc_pkg::GPC_TRIG_LOW_LEVEL && port_irq_request |=> !port_irq_request)
        else $error("edge request longer than one cycle");
endmodule : gpc_port_config_properties

bind gpc_port_config gpc_port_config_properties u_props (.clk, .resetn,
    .bus_addr, .bus_wdata, .bus_write, .bus_read, .bus_rdata, .pin_in_a,
    .pin_oe_b, .pin_out_b, .pin_oe_c, .pullup_en_c, .analog_sel_a,
    .analog_sel_c, .trigger_mode_c, .port_irq_request, .timer_pwm_out_enable,
    .auto_timer_pwm_pin, .spi_data_in, .uart_transmit_active,
    .uart_transmit_pin);
`default_nettype wire

// [verification/gpc_pad_model.sv]
`timescale 1ns/100ps
`default_nettype none
module gpc_pad_model (
    // Clock for the pattern on released lines.
    input  wire logic       clk,
    // Port drive and board drive.
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pullup_en,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    // Resolved pad level.
    output logic      [7:0] pin_level
);
    logic [7:0] drift = 8'h55;

    // A line nobody drives wanders, so a floating read never looks stable.
    always @(posedge clk) drift <= ~drift;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) pin_level[i] = pin_out[i];
            else if (ext_en[i]) pin_level[i] = ext_val[i];
            else if (pullup_en[i]) pin_level[i] = 1'b1;
            else pin_level[i] = drift[i];
        end
    end
endmodule : gpc_pad_model
`default_nettype wire

// [verification/gpc_port_config_test.sv]
`timescale 1ns/100ps
`default_nettype none
`include "gpc_regs.svh"
module gpc_port_config_test;
    logic clk = 1'b0, resetn = 1'b0, bus_write = 1'b0, bus_read = 1'b0;
    logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, bus_rdata, d, cnt;
    logic [7:0] pin_in_a, pin_out_a, pin_oe_a, pullup_en_a, analog_sel_a;
    logic [7:0] pin_in_b, pin_out_b, pin_oe_b, pullup_en_b, analog_sel_b;
    logic [7:0] pin_in_c, pin_out_c, pin_oe_c, pullup_en_c, analog_sel_c;
    logic [7:0] ext_en_a = 8'h00, ext_en_c = 8'h00, ext_val_c = 8'h00;
    logic [7:0] ext_en_b = 8'h02;
    logic pwm_en = 1'b0, pwm_pin = 1'b0, spi_out = 1'b1, utx_act = 1'b0;
    logic utx_pin = 1'b0, irq, timer_in, spi_in, spi_clk, urx;
    gpc_pkg::gpc_trigger_type none_mode = gpc_pkg::gpc_trigger_type'(2'h3);
    gpc_pkg::gpc_trigger_type trig_c = gpc_pkg::gpc_trigger_type'(2'h3);
    int num_errors = 0, n_tests = 0, cycles = 0;
    logic [7:0] regs [6] = '{`GPC_ADDR_DIR_A, `GPC_ADDR_DIR_B,
        `GPC_ADDR_DIR_C, `GPC_ADDR_OPTION_A, `GPC_ADDR_OPTION_B,
        `GPC_ADDR_OPTION_C};

    always #10 clk = ~clk;

    gpc_port_config uut (.clk, .resetn, .bus_addr, .bus_wdata, .bus_write,
        .bus_read, .bus_rdata, .pin_in_a, .pin_out_a, .pin_oe_a, .pullup_en_a,
        .analog_sel_a, .pin_in_b, .pin_out_b, .pin_oe_b, .pullup_en_b,
        .analog_sel_b, .pin_in_c, .pin_out_c, .pin_oe_c, .pullup_en_c,
        .analog_sel_c, .trigger_mode_a(none_mode), .trigger_mode_b(none_mode),
        .trigger_mode_c(trig_c), .port_irq_request(irq),
        .timer_pwm_out_enable(pwm_en), .auto_timer_pwm_pin(pwm_pin),
        .auto_timer_input_pin(timer_in), .spi_data_out(spi_out),
        .spi_data_in(spi_in), .spi_clock_in(spi_clk),
        .uart_transmit_active(utx_act), .uart_transmit_pin(utx_pin),
        .uart_receive_pin(urx));
    gpc_pad_model pad_a (.clk, .pin_out(pin_out_a), .pin_oe(pin_oe_a),
        .pullup_en(pullup_en_a), .ext_en(ext_en_a), .ext_val(8'h00),
        .pin_level(pin_in_a));
    gpc_pad_model pad_b (.clk, .pin_out(pin_out_b), .pin_oe(pin_oe_b),
        .pullup_en(pullup_en_b), .ext_en(ext_en_b), .ext_val(8'h00),
        .pin_level(pin_in_b));
    gpc_pad_model pad_c (.clk, .pin_out(pin_out_c), .pin_oe(pin_oe_c),
        .pullup_en(pullup_en_c), .ext_en(ext_en_c), .ext_val(ext_val_c),
        .pin_level(pin_in_c));

    task automatic check(input string name, input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, v);
        @(negedge clk);
        bus_addr = a;
        bus_wdata = v;
        bus_write = 1'b1;
        @(negedge clk);
        bus_write = 1'b0;
    endtask : wr

    // Read data is registered at the read edge and stands from then on.
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clk);
        bus_addr = a;
        bus_read = 1'b1;
        @(negedge clk);
        bus_read = 1'b0;
        v = bus_rdata;
    endtask : rd

    task automatic wr_rd(input logic [7:0] a, v, output logic [7:0] r);
        wr(a, v);
        bus_read = 1'b1;
        @(negedge clk);
        bus_read = 1'b0;
        r = bus_rdata;
    endtask : wr_rd

    task automatic cfg(input logic [7:0] da, oa, va, dv, ov, vv);
        wr(da, dv);
        wr(oa, ov);
        wr(va, vv);
        repeat (8) @(negedge clk);
    endtask : cfg

    task automatic count_irq(input logic [7:0] exp);
        cnt = 8'h00;
        repeat (10) begin
            @(negedge clk);
            cnt = cnt + {7'h00, irq};
        end
        check("irq_cycles", cnt, exp);
    endtask : count_irq

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            results();
        end
    end

    initial begin
        repeat (5) @(negedge clk);
        check("pullup_c", pullup_en_c, 8'hFF);
        resetn = 1'b1;
        repeat (3) @(negedge clk);
        foreach (regs[i]) begin
            rd(regs[i], d);
            check("reset_reg", d, 8'h00);
            wr_rd(regs[i], 8'h5A ^ 8'(i), d);
            check("reg_rw", d, 8'h5A ^ 8'(i));
        end
        rd(8'hC7, d);
        check("unmapped", d, 8'h00);
        ext_en_c = 8'hA0;
        ext_val_c = 8'h80;
        // Whole-byte writes; only port C line 7 becomes analog.
        cfg(`GPC_ADDR_DIR_A, `GPC_ADDR_OPTION_A, `GPC_ADDR_VALUE_A,
            8'h0F, 8'hC5, 8'hA6);
        cfg(`GPC_ADDR_DIR_B, `GPC_ADDR_OPTION_B, `GPC_ADDR_VALUE_B,
            8'h0D, 8'hC5, 8'h24);
        cfg(`GPC_ADDR_DIR_C, `GPC_ADDR_OPTION_C, `GPC_ADDR_VALUE_C,
            8'h0F, 8'hC5, 8'hA6);
        check("oe_c", pin_oe_c, 8'h0D);
        check("out_c", pin_out_c & pin_oe_c, 8'h04);
        check("pullup_c", pullup_en_c, 8'h50);
        check("analog_c", analog_sel_c, 8'h80);
        check("analog_a", analog_sel_a, 8'h00);
        check("pullup_b", pullup_en_b, 8'hD2);
        check("analog_b", analog_sel_b, 8'h00);
        check("timer_in", {7'h00, timer_in}, 8'h01);
        check("uart_rx", {7'h00, urx}, 8'h00);
        rd(`GPC_ADDR_VALUE_C, d);
        check("value_c", d, 8'hD6);
        pwm_en = 1'b1;
        pwm_pin = 1'b1;
        #1 check("pwm_hi", {6'h00, pin_oe_b[7], pin_out_b[7]}, 8'h03);
        pwm_pin = 1'b0;
        #1 check("pwm_lo", {6'h00, pin_oe_b[7], pin_out_b[7]}, 8'h02);
        pwm_en = 1'b0;
        #1 check("pwm_off", {7'h00, pin_oe_b[7]}, 8'h00);
        utx_act = 1'b1;
        utx_pin = 1'b1;
        #1 check("tx_hi", {6'h00, pin_oe_b[0], pin_out_b[0]}, 8'h03);
        utx_act = 1'b0;
        #1 check("tx_off", {6'h00, pin_oe_b[0], pin_out_b[0]}, 8'h02);
        ext_en_a = 8'h40;
        cfg(`GPC_ADDR_DIR_A, `GPC_ADDR_OPTION_A, `GPC_ADDR_VALUE_A,
            8'h80, 8'h00, 8'h80);
        check("od_rel", {7'h00, pin_oe_a[7]}, 8'h00);
        check("pullup_a", pullup_en_a, 8'h7F);
        spi_out = 1'b0;
        #1 check("od_spi", {6'h00, pin_oe_a[7], pin_out_a[7]}, 8'h02);
        check("spi_in", {7'h00, spi_in}, 8'h00);
        check("spi_clk", {7'h00, spi_clk}, 8'h01);
        rd(`GPC_ADDR_VALUE_A, d);
        check("value_a", d, 8'hBF);
        wr(`GPC_ADDR_OPTION_A, 8'h80);
        #1 check("pp_spi", {6'h00, pin_oe_a[7], pin_out_a[7]}, 8'h03);
        trig_c = gpc_pkg::GPC_TRIG_FALLING;
        ext_en_c = 8'hE0;
        count_irq(8'h01);
        trig_c = gpc_pkg::GPC_TRIG_RISING;
        ext_val_c = 8'hC0;
        count_irq(8'h01);
        trig_c = none_mode;
        ext_val_c = 8'h80;
        count_irq(8'h00);
        trig_c = gpc_pkg::GPC_TRIG_LOW_LEVEL;
        repeat (3) @(negedge clk);
        count_irq(8'h0A);
        trig_c = none_mode;
        repeat (3) @(negedge clk);
        count_irq(8'h00);
        results();
    end
endmodule : gpc_port_config_test
`default_nettype wire
